// *** core/ifsr_regs.vh ***
// Register offsets, field positions and reset values of the interrupt enable/status block.
// Included by core/ifsr_core.v; definitions only.
`ifndef IFSR_REGS_VH
`define IFSR_REGS_VH
`define IFSR_OFF_IRQ_STATUS 12'h000
`define IFSR_OFF_IRQ_RAW 12'h004
`define IFSR_OFF_IRQ_ENABLE_SET 12'h008
`define IFSR_OFF_IRQ_ENABLE_CLEAR 12'h00c
`define IFSR_OFF_SOFT_IRQ_REQUEST 12'h010
`define IFSR_OFF_FAST_MASKED_STATUS 12'h100
`define IFSR_OFF_FAST_RAW_STATUS 12'h104
`define IFSR_OFF_FAST_ENABLE_SET 12'h108
`define IFSR_OFF_FAST_ENABLE_CLEAR 12'h10c
`define IFSR_OFF_IRQ_STEER 12'h110
`define IFSR_GEN_MSB 15
`define IFSR_GEN_LSB 1
`define IFSR_FAST_BIT 0
`define IFSR_SOFT_BIT 1
`define IFSR_GEN_MASK 16'hfffe
`define IFSR_RST_ENABLE 16'h0000
`define IFSR_RST_STEER 16'h0000
`define IFSR_RST_FAST_EN 1'b0
`define IFSR_RST_SOFT 1'b0
`define IFSR_RST_STATUS 32'h0000_0000
`endif

// *** core/ifsr_core.v ***
// Interrupt enable, enable-clear, software request and fast status/enable registers.
// Assumes a simple synchronous register port on clk_in; sources are async pins.
//
// Functional notes
// R1: General enable bits 15:2 gate each source onto the normal request; bit 1 (software) is not gated.
// R2: Writing one sets an enable; zero leaves it; steering picks normal or fast.
// R3: Enable bits 31:16 and bit 0 are reserved, no enable function.
// R4: Enable-clear is write-only; one clears matching enable bit 15:1.
// R5: Disabled source not in masked status; level still in raw status.
// R6: Software request write-only; bit 1 one raises, zero withdraws request.
// R7: Software request bits 31:2 and 0 reserved, ignored on write.
// R8: Fast masked status read-only, shows fast and steered sources after masking.
// R9: Fast masked bits 15:1 one when source active, enabled, steered and fast enable set.
// R10: Fast masked bit 0 one while enabled fast request pending; resets zero.
// R11: Fast raw status read-only, levels before masking; resets zero.
// R12: Fast raw bits 15:1 one when source active and steered, any enable.
// R13: Fast raw bit 0 follows the unmasked fast input.
// R14: Fast enable readable; writing one to bit 0 sets it, zero ignored.
// R15: With fast enable set, fast and steered requests reach fast masked status.
// R16: Steer bit one routes source to fast status, zero to normal status.
// R17: Fast enable-clear bit 0 one disables fast request; raw stays visible.
// R18: Normal raw status shows non-steered levels before masking.
// R19: Normal output while any normal masked bit 15:1 set; fast output while any fast masked bit set.
// R20: Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "ifsr_regs.vh"

module ifsr_core (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Register port
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [11:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_ack_out,
  // Interrupt sources, asynchronous levels
  input wire [15:2] gen_src_in,
  input wire fast_interrupt_request_in,
  // Requests toward the processor
  output reg irq_out,
  output reg fast_req_out
);

  reg [15:0] src_s1_q;
  reg [15:0] src_s2_q;
  reg [15:0] src_s3_q;
  reg [15:0] src_q;
  reg [15:0] enable_q;
  reg [15:0] steer_q;
  reg fast_en_q;
  reg soft_q;
  reg [15:0] irq_raw_d;
  reg [15:0] irq_stat_d;
  reg [15:0] fast_raw_d;
  reg [15:0] fast_stat_d;
  reg [15:0] irq_raw_q;
  reg [15:0] irq_stat_q;
  reg [15:0] fast_raw_q;
  reg [15:0] fast_stat_q;
  reg [31:0] rdata_d;
  wire [15:0] src_pins;
  wire [15:0] src_now;
  wire [15:0] wgen;

  assign src_pins = {gen_src_in, 1'b0, fast_interrupt_request_in};
  assign wgen = reg_wdata_in[15:0] & `IFSR_GEN_MASK;
  // Software source is internal, no synchroniser needed
  assign src_now = {src_q[15:2], soft_q, src_q[0]};

  // Three-stage synchroniser; change accepted when stages two and three agree
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      src_s1_q <= 16'h0000;
      src_s2_q <= 16'h0000;
      src_s3_q <= 16'h0000;
      src_q <= 16'h0000;
    end else begin
      src_s1_q <= src_pins;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
      src_q <= (src_s2_q & src_s3_q) | (src_q & (src_s2_q | src_s3_q));
    end
  end

  // Control registers
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      enable_q <= `IFSR_RST_ENABLE;
      steer_q <= `IFSR_RST_STEER;
      fast_en_q <= `IFSR_RST_FAST_EN;
      soft_q <= `IFSR_RST_SOFT;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `IFSR_OFF_IRQ_ENABLE_SET) begin
        enable_q <= enable_q | wgen; // see R2, see R3, see R20
      end else if (reg_addr_in == `IFSR_OFF_IRQ_ENABLE_CLEAR) begin
        enable_q <= enable_q & ~wgen; // see R4
      end else if (reg_addr_in == `IFSR_OFF_SOFT_IRQ_REQUEST) begin
        soft_q <= reg_wdata_in[`IFSR_SOFT_BIT]; // see R6, see R7
      end else if (reg_addr_in == `IFSR_OFF_FAST_ENABLE_SET) begin
        fast_en_q <= fast_en_q | reg_wdata_in[`IFSR_FAST_BIT]; // see R14
      end else if (reg_addr_in == `IFSR_OFF_FAST_ENABLE_CLEAR) begin
        fast_en_q <= fast_en_q & ~reg_wdata_in[`IFSR_FAST_BIT]; // see R17
      end else if (reg_addr_in == `IFSR_OFF_IRQ_STEER) begin
        steer_q <= wgen;
      end
    end
  end

  // Status derivation
  always @* begin
    irq_raw_d = src_now & ~steer_q; // see R16, see R18
    irq_raw_d[`IFSR_FAST_BIT] = src_now[`IFSR_FAST_BIT];
    irq_stat_d = irq_raw_d & enable_q; // see R1, see R5
    // Software request needs no enable
    irq_stat_d[`IFSR_SOFT_BIT] = irq_raw_d[`IFSR_SOFT_BIT];
    irq_stat_d[`IFSR_FAST_BIT] = src_now[`IFSR_FAST_BIT] & fast_en_q;
    fast_raw_d = src_now & steer_q; // see R12, see R16
    fast_raw_d[`IFSR_FAST_BIT] = src_now[`IFSR_FAST_BIT]; // see R13, see R17
    fast_stat_d = fast_raw_d & enable_q & {16{fast_en_q}}; // see R8, see R9, see R15
    fast_stat_d[`IFSR_FAST_BIT] = src_now[`IFSR_FAST_BIT] & fast_en_q; // see R10
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_raw_q <= 16'h0000;
      irq_stat_q <= 16'h0000;
      fast_raw_q <= 16'h0000; // see R11
      fast_stat_q <= 16'h0000;
      irq_out <= 1'b0;
      fast_req_out <= 1'b0;
    end else begin
      irq_raw_q <= irq_raw_d;
      irq_stat_q <= irq_stat_d;
      fast_raw_q <= fast_raw_d;
      fast_stat_q <= fast_stat_d;
      irq_out <= |irq_stat_d[15:1]; // see R19
      fast_req_out <= |fast_stat_d; // see R19
    end
  end

  // Read decode; write-only and unmapped read zero
  always @* begin
    rdata_d = `IFSR_RST_STATUS;
    if (reg_addr_in == `IFSR_OFF_IRQ_STATUS) begin
      rdata_d[15:0] = irq_stat_q;
    end else if (reg_addr_in == `IFSR_OFF_IRQ_RAW) begin
      rdata_d[15:0] = irq_raw_q;
    end else if (reg_addr_in == `IFSR_OFF_IRQ_ENABLE_SET) begin
      rdata_d[15:0] = enable_q; // see R20
    end else if (reg_addr_in == `IFSR_OFF_FAST_MASKED_STATUS) begin
      rdata_d[15:0] = fast_stat_q; // see R8
    end else if (reg_addr_in == `IFSR_OFF_FAST_RAW_STATUS) begin
      rdata_d[15:0] = fast_raw_q; // see R11
    end else if (reg_addr_in == `IFSR_OFF_FAST_ENABLE_SET) begin
      rdata_d[`IFSR_FAST_BIT] = fast_en_q; // see R14
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= `IFSR_RST_STATUS;
      reg_ack_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_d : `IFSR_RST_STATUS;
      reg_ack_out <= reg_rd_in | reg_wr_in;
    end
  end

endmodule
`default_nettype wire

// *** test/ifsr_cpu.sv ***
// Core-side model; takes the request levels each clock.
`timescale 1ns/100ps
`default_nettype none
module ifsr_cpu (
  // Requests in, taken levels out
  input wire logic clk_in,
  input wire logic irq_in,
  input wire logic fast_in,
  output logic [1:0] seen_out
);
  always @(posedge clk_in) seen_out <= {irq_in, fast_in};
endmodule
`default_nettype wire

// *** test/ifsr_core_chk.sv ***
// Port checker for ifsr_core, bound below.
`timescale 1ns/100ps
`default_nettype none
module ifsr_chk (
  // Clock, reset, register port, requests
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic irq_out,
  input wire logic fast_req_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_ack_follows: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out) else $error("no ack");
  a_ack_alone: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out) else $error("ack");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("idle data");
  a_rsvd_zero: assert property (reg_rd_in |=> reg_rdata_out[31:16] == 16'h0)
    else $error("upper bits");
  a_wo_reads: assert property (
    reg_rd_in && reg_addr_in inside {12'h00c, 12'h010} |=> reg_rdata_out == 32'h0)
    else $error("write-only read");
  a_fast_en_rsvd: assert property (
    reg_rd_in && reg_addr_in == 12'h108 |=> reg_rdata_out[31:1] == 31'h0) else $error("bits");
  a_fast_clear: assert property (
    reg_wr_in && reg_addr_in == 12'h10c && reg_wdata_in[0] ##1
    !(reg_wr_in && reg_addr_in == 12'h108) |=> !fast_req_out) else $error("fast kept");
  a_rst_quiet: assert property ($fell(sys_rst_in) |-> !irq_out && !fast_req_out)
    else $error("reset request");
endmodule
bind ifsr_core ifsr_chk chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .irq_out(irq_out),
  .fast_req_out(fast_req_out));
`default_nettype wire

// *** test/test_ifsr_core.sv ***
// Random bench for ifsr_core with the core model on its requests.
`timescale 1ns/100ps
`default_nettype none
module test_ifsr_core;
  logic clk_in = 0, rst = 1, wr = 0, rd = 0, fast = 0, fe;
  logic [11:0] ad = 12'h0;
  logic [31:0] wd = 32'h0, q, a, b, c, w, s, t;
  logic [15:2] src = 14'h0;
  logic [15:0] en, v;
  wire [31:0] rq;
  wire [1:0] seen;
  wire ack, irq, frq;
  int fail_count = 0, total_checks = 0, i;
  always #25 clk_in = ~clk_in;
  ifsr_core dut (.clk_in(clk_in), .sys_rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rq), .reg_ack_out(ack),
    .gen_src_in(src), .fast_interrupt_request_in(fast), .irq_out(irq), .fast_req_out(frq));
  ifsr_cpu cpu (.clk_in(clk_in), .irq_in(irq), .fast_in(frq), .seen_out(seen));
  function automatic logic [31:0] st(input logic [15:0] m, input logic b0);
    return {16'h0, v[15:1] & m[15:1], b0};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic k, input logic [11:0] x, input logic [31:0] d);
    {wr, rd, ad, wd} = {k, !k, x, d};
    @(posedge clk_in);
    #1 {wr, rd, q} = {2'b0, rq};
    @(posedge clk_in);
    #1;
  endtask
  task automatic rc(input string n, input logic [11:0] x, input logic [31:0] e);
    bus(1'b0, x, 32'h0);
    chk(n, e, q);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    a = $urandom(85787);
    repeat (10) @(posedge clk_in);
    #1 rst = 0;
    rc("fast_st", 12'h100, 32'h0);
    for (i = 0; i < 40; i++) begin
      {a, b, c, w, s, t} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      {src, fast} = 15'($urandom);
      if (i == 0) {a, c} = {32'hffff_ffff, 32'h0};
      if (i == 1) c = 32'hffff_ffff;
      bus(1'b1, 12'h00c, 32'hffff);
      bus(1'b1, 12'h008, a);
      bus(1'b1, 12'h008, b);
      bus(1'b1, 12'h00c, c);
      bus(1'b1, 12'h110, s);
      bus(1'b1, 12'h10c, 32'h1);
      bus(1'b1, 12'h108, w);
      bus(1'b1, 12'h10c, c);
      bus(1'b1, 12'h010, t);
      bus(1'b1, 12'h104, a);
      en = (a[15:0] | b[15:0]) & ~c[15:0] & 16'hfffe;
      fe = w[0] & ~c[0];
      v = {src, t[1], fast};
      rc("irq_st", 12'h000, st(~s[15:0] & (en | 16'h2), fast & fe));
      rc("irq_raw", 12'h004, st(~s[15:0], fast));
      rc("irq_en", 12'h008, {16'h0, en});
      rc("fast_st", 12'h100, st(s[15:0] & en & {16{fe}}, fast & fe));
      rc("fast_raw", 12'h104, st(s[15:0], fast));
      rc("fast_en", 12'h108, {31'h0, fe});
      rc("unmapped", 12'h020, 32'h0);
      chk("core_irq", {31'h0, |st(~s[15:0] & (en | 16'h2), 1'b0)}, {31'h0, seen[1]});
      chk("core_fast", {31'h0, |st(s[15:0] & en & {16{fe}}, fast & fe)}, {31'h0, seen[0]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
